// [ddcpb_defs.vh]
// Behaviour
// - dual mode, mode 0: chan b field picks b preset
// - single mode: b preset follows chan a selection
// - mode 0: chan a field picks a preset
// - binding bit 1 routes converter to b
// - binding bit 0 routes converter to a
// - digital channel follows bound converter powerdown
// - divisor zero gives plain 32-bit accumulator
// - one divisor serves every preset
// - mode 0 register, 1 pairs, 2 shared
`ifndef DDCPB_DEFS_VH
`define DDCPB_DEFS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define DDCPB_ADDR_W 12
`define DDCPB_OFF_MODE 12'h214
`define DDCPB_OFF_PRESET 12'h215
`define DDCPB_OFF_BIND 12'h216
`define DDCPB_OFF_RDIV_LO 12'h217
`define DDCPB_OFF_RDIV_HI 12'h218
`define DDCPB_OFF_CTRL 12'h21a
`define DDCPB_OFF_STATUS 12'h21b
// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define DDCPB_RST_MODE 8'h00
`define DDCPB_RST_PRESET 8'h00
`define DDCPB_RST_BIND 8'h02
`define DDCPB_RST_RDIV 16'h0000
`define DDCPB_RST_CTRL 8'h00
`define DDCPB_CTRL_DUAL 0
`define DDCPB_CTRL_PD_A 1
`define DDCPB_CTRL_PD_B 2
`define DDCPB_MODE_REG 2'h0
`define DDCPB_MODE_PAIRS 2'h1
`define DDCPB_MODE_SHARED 2'h2
`endif

// [ddcpb_fifo.v]
module ddcpb_fifo #(
   parameter WIDTH = 12,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire clock,
   input wire reset,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire do_wr;
   wire do_rd;
   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign do_wr = in_valid & in_ready;
   assign do_rd = out_valid & out_ready;
   always @(posedge clock) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
      if (reset) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         end
         if (do_wr & ~do_rd) begin
            count <= count + 1'b1;
         end else if (do_rd & ~do_wr) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // ddcpb_fifo

// [ddcpb_top.v]
// Our own choice: the address-and-strobe port.
`include "ddcpb_defs.vh"
module ddcpb_top #(
   parameter DATA_W = 12,
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3
) (
   input wire clock,
   input wire reset,
   input wire [11:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [7:0] reg_rdata,
   input wire [1:0] preset_pins_a,
   input wire [1:0] preset_pins_b,
   input wire [DATA_W-1:0] conv_a_data,
   input wire conv_a_valid,
   input wire [DATA_W-1:0] conv_b_data,
   input wire conv_b_valid,
   output wire conv_a_ready,
   output reg [DATA_W-1:0] chan_a_data,
   output reg chan_a_valid,
   input wire chan_a_ready,
   output reg [DATA_W-1:0] chan_b_data,
   output reg chan_b_valid,
   output reg [1:0] active_preset_a,
   output reg [1:0] active_preset_b,
   output reg [15:0] nco_reference_divisor_out,
   output reg divisor_enable,
   output reg chan_a_powerdown,
   output reg chan_b_powerdown
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [7:0] preset_selection_mode;
   reg [7:0] nco_preset_select;
   reg [7:0] digital_channel_binding;
   reg [15:0] nco_reference_divisor;
   reg [7:0] ctrl;
   reg [1:0] pins_a_meta;
   reg [1:0] pins_a_sync;
   reg [1:0] pins_b_meta;
   reg [1:0] pins_b_sync;
   reg [7:0] next_rdata;
   reg [1:0] next_preset_a;
   reg [1:0] next_preset_b;
   wire dual;
   wire [1:0] mode;
   wire [1:0] field_a;
   wire [1:0] field_b;
   wire src_a_is_b;
   wire src_b_is_b;
   wire pd_a;
   wire pd_b;
   wire [DATA_W-1:0] fifo_in_data;
   wire fifo_in_valid;
   wire [DATA_W-1:0] fifo_out_data;
   wire fifo_out_valid;
   wire fifo_out_ready;
   wire fifo_in_ready;

   assign dual = ctrl[`DDCPB_CTRL_DUAL];
   assign mode = preset_selection_mode[1:0];
   assign field_a = nco_preset_select[1:0];
   assign field_b = nco_preset_select[3:2];
   assign src_a_is_b = digital_channel_binding[0];
   assign src_b_is_b = digital_channel_binding[1];

   function bound_pd;
      input sel_b;
      input pda;
      input pdb;
      begin
         bound_pd = sel_b ? pdb : pda;
      end
   endfunction
   assign pd_a = bound_pd(src_a_is_b, ctrl[`DDCPB_CTRL_PD_A], ctrl[`DDCPB_CTRL_PD_B]);
   assign pd_b = bound_pd(src_b_is_b, ctrl[`DDCPB_CTRL_PD_A], ctrl[`DDCPB_CTRL_PD_B]);

   // ----------------------------------------
   // register port
   // ----------------------------------------
   // full readback
   always @(posedge clock) begin
      if (reset) begin
         preset_selection_mode <= `DDCPB_RST_MODE;
         nco_preset_select <= `DDCPB_RST_PRESET;
         digital_channel_binding <= `DDCPB_RST_BIND;
         nco_reference_divisor <= `DDCPB_RST_RDIV;
         ctrl <= `DDCPB_RST_CTRL;
      end else if (reg_write) begin
         case (reg_addr)
            `DDCPB_OFF_MODE: preset_selection_mode <= reg_wdata;
            `DDCPB_OFF_PRESET: nco_preset_select <= reg_wdata;
            `DDCPB_OFF_BIND: digital_channel_binding <= reg_wdata;
            `DDCPB_OFF_RDIV_LO: nco_reference_divisor[7:0] <= reg_wdata;
            `DDCPB_OFF_RDIV_HI: nco_reference_divisor[15:8] <= reg_wdata;
            `DDCPB_OFF_CTRL: ctrl <= reg_wdata;
            default: ;
         endcase
      end
   end

   always @* begin
      next_rdata = 8'h00;
      case (reg_addr)
         `DDCPB_OFF_MODE: next_rdata = preset_selection_mode;
         `DDCPB_OFF_PRESET: next_rdata = nco_preset_select;
         `DDCPB_OFF_BIND: next_rdata = digital_channel_binding;
         `DDCPB_OFF_RDIV_LO: next_rdata = nco_reference_divisor[7:0];
         `DDCPB_OFF_RDIV_HI: next_rdata = nco_reference_divisor[15:8];
         `DDCPB_OFF_CTRL: next_rdata = ctrl;
         `DDCPB_OFF_STATUS: next_rdata = {2'h0, active_preset_b, active_preset_a,
                                          chan_b_powerdown, chan_a_powerdown};
         default: next_rdata = 8'h00;
      endcase
   end

   // read data stands one cycle only
   always @(posedge clock) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ----------------------------------------
   // preset pins, two-stage sync
   // ----------------------------------------
   always @(posedge clock) begin
      if (reset) begin
         pins_a_meta <= 2'h0;
         pins_a_sync <= 2'h0;
         pins_b_meta <= 2'h0;
         pins_b_sync <= 2'h0;
      end else begin
         pins_a_meta <= preset_pins_a;
         pins_a_sync <= pins_a_meta;
         pins_b_meta <= preset_pins_b;
         pins_b_sync <= pins_b_meta;
      end
   end

   // ----------------------------------------
   // active preset selection
   // ----------------------------------------
   always @* begin
      next_preset_a = active_preset_a;
      next_preset_b = active_preset_b;
      case (mode)
         `DDCPB_MODE_REG: begin
            next_preset_a = field_a;
            next_preset_b = field_b;
         end
         `DDCPB_MODE_PAIRS: begin
            next_preset_a = pins_a_sync;
            next_preset_b = pins_b_sync;
         end
         `DDCPB_MODE_SHARED: begin
            next_preset_a = pins_a_sync;
            next_preset_b = pins_a_sync;
         end
         // reserved code holds last selection
         default: ;
      endcase
      if (!dual) begin
         next_preset_b = next_preset_a;
      end
   end

   always @(posedge clock) begin
      if (reset) begin
         active_preset_a <= 2'h0;
         active_preset_b <= 2'h0;
         nco_reference_divisor_out <= `DDCPB_RST_RDIV;
         divisor_enable <= 1'b0;
         chan_a_powerdown <= 1'b0;
         chan_b_powerdown <= 1'b0;
      end else begin
         active_preset_a <= next_preset_a;
         active_preset_b <= next_preset_b;
         nco_reference_divisor_out <= nco_reference_divisor;
         divisor_enable <= (nco_reference_divisor != 16'h0000);
         chan_a_powerdown <= pd_a;
         chan_b_powerdown <= pd_b;
      end
   end

   // ----------------------------------------
   // data routing
   // ----------------------------------------
   // channel a source, buffered
   assign fifo_in_data = src_a_is_b ? conv_b_data : conv_a_data;
   assign fifo_in_valid = (src_a_is_b ? conv_b_valid : conv_a_valid) & ~pd_a;
   // stall only the converter a path; b source is never stalled
   assign conv_a_ready = fifo_in_ready;
   assign fifo_out_ready = chan_a_ready | ~chan_a_valid;

   ddcpb_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clock(clock),
      .reset(reset),
      .in_data(fifo_in_data),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready)
   );

   always @(posedge clock) begin
      if (reset) begin
         chan_a_data <= {DATA_W{1'b0}};
         chan_a_valid <= 1'b0;
         chan_b_data <= {DATA_W{1'b0}};
         chan_b_valid <= 1'b0;
      end else begin
         if (fifo_out_ready) begin
            chan_a_data <= fifo_out_data;
            chan_a_valid <= fifo_out_valid & ~pd_a;
         end
         chan_b_data <= src_b_is_b ? conv_b_data : conv_a_data;
         chan_b_valid <= (src_b_is_b ? conv_b_valid : conv_a_valid) & ~pd_b;
      end
   end
endmodule // ddcpb_top

// [ddcpb_chk.sv]
module ddcpb_chk #(parameter DATA_W = 12) (
   input wire clock,
   input wire reset,
   input wire [11:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   input wire [7:0] reg_rdata,
   input wire [DATA_W-1:0] conv_b_data,
   input wire conv_b_valid,
   input wire conv_a_ready,
   input wire [DATA_W-1:0] chan_b_data,
   input wire chan_b_valid,
   input wire [1:0] active_preset_a,
   input wire [1:0] active_preset_b,
   input wire [15:0] nco_reference_divisor_out,
   input wire divisor_enable,
   input wire chan_a_powerdown,
   input wire chan_b_powerdown
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // shadow of mode, binding and control
   // ----------------------------------------
   reg [1:0] mode;
   reg [7:0] bind_r;
   reg [2:0] ctl;
   wire w215 = reg_write && reg_addr == 12'h215 && mode == 2'h0;
   always @(posedge clock) begin
      if (reset) begin
         mode <= 2'h0;
         bind_r <= 8'h02;
         ctl <= 3'h0;
      end else if (reg_write) begin
         if (reg_addr == 12'h214) mode <= reg_wdata[1:0];
         if (reg_addr == 12'h216) bind_r <= reg_wdata;
         if (reg_addr == 12'h21a) ctl <= reg_wdata[2:0];
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   rd_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("rdata not idle");
   rd_bind_a: assert property (reg_read && reg_addr == 12'h216 |=> reg_rdata == bind_r)
      else $error("binding readback");
   // register then output stage: active preset shows two edges after the write
   preset_a_a: assert property (w215 |-> ##2 active_preset_a == $past(reg_wdata[1:0], 2))
      else $error("preset a");
   preset_b_a: assert property (w215 && ctl[0] |-> ##2 active_preset_b == $past(reg_wdata[3:2], 2))
      else $error("preset b dual");
   single_b_a: assert property (w215 && !ctl[0] |-> ##2 active_preset_b == $past(reg_wdata[1:0], 2))
      else $error("preset b single");
   div_lo_a: assert property (reg_write && reg_addr == 12'h217
      |-> ##2 nco_reference_divisor_out[7:0] == $past(reg_wdata, 2))
      else $error("divisor low");
   div_en_a: assert property (divisor_enable == (nco_reference_divisor_out != 16'h0000))
      else $error("divisor enable");
   pd_map_a: assert property ({chan_b_powerdown, chan_a_powerdown} ==
      $past({bind_r[1] ? ctl[2] : ctl[1], bind_r[0] ? ctl[2] : ctl[1]}))
      else $error("powerdown map");
   bind_b_a: assert property ($past(conv_b_valid) && $past(bind_r[1]) && !chan_b_powerdown
      && !$past(chan_b_powerdown) |-> chan_b_valid && chan_b_data == $past(conv_b_data))
      else $error("chan b route");
   cover property (w215 && ctl[0]);
   cover property (chan_b_valid && !bind_r[1]);
   cover property (!conv_a_ready);
endmodule // ddcpb_chk

bind ddcpb_top ddcpb_chk #(.DATA_W(DATA_W)) i_chk (
   .clock(clock),
   .reset(reset),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_write(reg_write),
   .reg_read(reg_read),
   .reg_rdata(reg_rdata),
   .conv_b_data(conv_b_data),
   .conv_b_valid(conv_b_valid),
   .conv_a_ready(conv_a_ready),
   .chan_b_data(chan_b_data),
   .chan_b_valid(chan_b_valid),
   .active_preset_a(active_preset_a),
   .active_preset_b(active_preset_b),
   .nco_reference_divisor_out(nco_reference_divisor_out),
   .divisor_enable(divisor_enable),
   .chan_a_powerdown(chan_a_powerdown),
   .chan_b_powerdown(chan_b_powerdown)
);

// [ddcpb_tb.sv]
module ddc_preset_select_channel_binding_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, reset = 1, reg_write = 0, reg_read = 0, chan_a_ready = 1;
   logic conv_a_valid = 0, conv_b_valid = 0;
   logic [11:0] reg_addr = 0, conv_a_data = 0, conv_b_data = 0, chan_a_data, chan_b_data;
   logic [7:0] reg_wdata = 0, reg_rdata;
   logic [1:0] preset_pins_a = 0, preset_pins_b = 0, active_preset_a, active_preset_b;
   logic [1:0] bnd = 2'h2;
   logic conv_a_ready, chan_a_valid, chan_b_valid, divisor_enable;
   logic chan_a_powerdown, chan_b_powerdown;
   logic [15:0] nco_reference_divisor_out;
   integer error_cnt = 0, compares = 0, seed = 86675, i, j, n;
   logic [11:0] q[$], qb[$];
   ddcpb_top i_dut (
      .clock(clock),
      .reset(reset),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_write(reg_write),
      .reg_read(reg_read),
      .reg_rdata(reg_rdata),
      .preset_pins_a(preset_pins_a),
      .preset_pins_b(preset_pins_b),
      .conv_a_data(conv_a_data),
      .conv_a_valid(conv_a_valid),
      .conv_b_data(conv_b_data),
      .conv_b_valid(conv_b_valid),
      .conv_a_ready(conv_a_ready),
      .chan_a_data(chan_a_data),
      .chan_a_valid(chan_a_valid),
      .chan_a_ready(chan_a_ready),
      .chan_b_data(chan_b_data),
      .chan_b_valid(chan_b_valid),
      .active_preset_a(active_preset_a),
      .active_preset_b(active_preset_b),
      .nco_reference_divisor_out(nco_reference_divisor_out),
      .divisor_enable(divisor_enable),
      .chan_a_powerdown(chan_a_powerdown),
      .chan_b_powerdown(chan_b_powerdown)
   );
   initial forever #20 clock = ~clock;
   task automatic chk(input string nm, input logic [15:0] s, e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task close_out;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1;
      @(posedge clock);
      reg_write <= 0;
   endtask
   task rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1;
      @(posedge clock);
      reg_read <= 0;
      #1 chk("rdata", reg_rdata, e);
   endtask
   // ----------------------------------------
   // stream model: source queues per channel
   // ----------------------------------------
   always @(posedge clock) begin
      if (!reset && (bnd[0] ? conv_b_valid : conv_a_valid) && conv_a_ready)
         q.push_back(bnd[0] ? conv_b_data : conv_a_data);
      if (bnd[1] ? conv_b_valid : conv_a_valid) qb.push_back(bnd[1] ? conv_b_data : conv_a_data);
      if (chan_a_valid && chan_a_ready) chk("chan_a", chan_a_data, q.pop_front());
      if (chan_b_valid) chk("chan_b", chan_b_data, qb.pop_front());
   end
   initial begin
      #100us;
      error_cnt++;
      close_out;
   end
   initial begin
      repeat (10) @(posedge clock);
      reset <= 0;
      for (i = 0; i < 9; i++) rd(12'h214 + 12'(i), (i == 2) ? 8'h02 : 8'h00);
      $display("reset values done");
      // random mode, preset, binding and divisor writes with readback while dual mode is on
      wr(12'h21a, 8'h01);
      for (i = 0; i < 5; i++) begin
         n = $random(seed);
         if (i == 4) n[7:5] = 3'h0;
         wr(12'h214 + 12'(i), n[7:0]);
         rd(12'h214 + 12'(i), n[7:0]);
      end
      $display("readback done");
      wr(12'h214, 8'h00);
      wr(12'h216, 8'h02);
      for (i = 0; i < 32; i++) begin
         n = i;
         wr(12'h21a, {7'h00, n[4]});
         wr(12'h215, n[7:0]);
         @(posedge clock);
         #1 chk("preset_a", active_preset_a, n[1:0]);
         chk("preset_b", active_preset_b, n[4] ? n[3:2] : n[1:0]);
      end
      $display("register preset done");
      wr(12'h21a, 8'h01);
      for (i = 1; i < 4; i++) begin
         n = i;
         wr(12'h214, n[7:0]);
         preset_pins_a <= n[1:0];
         preset_pins_b <= n[1:0] + 2'h1;
         repeat (4) @(posedge clock);
         #1 chk("pin_a", active_preset_a, (i == 3) ? 2'h2 : n[1:0]);
         chk("pin_b", active_preset_b, 2'h2);
      end
      $display("pin preset done");
      for (i = 0; i < 2; i++) begin
         n = (i == 1) ? 0 : ($random(seed) & 32'h1fff);
         wr(12'h217, n[7:0]);
         wr(12'h218, n[15:8]);
         @(posedge clock);
         #1 chk("divisor", nco_reference_divisor_out, n[15:0]);
         chk("div_en", divisor_enable, n[15:0] != 0);
      end
      $display("divisor done");
      for (i = 0; i < 5; i++) begin
         n = (i == 4) ? 2 : i;
         wr(12'h216, n[7:0]);
         bnd = n[1:0];
         for (j = 0; j < 4; j++) begin
            wr(12'h21a, {5'h00, 2'(j), 1'b1});
            @(posedge clock);
            #1 chk("pd_a", chan_a_powerdown, n[0] ? j[1] : j[0]);
            chk("pd_b", chan_b_powerdown, n[1] ? j[1] : j[0]);
         end
         // both converters down, presets held at 2 by the reserved mode
         rd(12'h21b, 8'h2b);
         wr(12'h21a, 8'h01);
         chan_a_ready <= (i < 4);
         repeat (14) begin
            @(posedge clock);
            if (conv_a_ready || !conv_a_valid) conv_a_data <= 12'($random(seed));
            conv_b_data <= 12'($random(seed));
            conv_a_valid <= 1;
            conv_b_valid <= (i < 4);
         end
         @(posedge clock);
         conv_a_valid <= 0;
         conv_b_valid <= 0;
         #1;
      end
      chk("fill", q.size(), 9);
      chk("full", conv_a_ready, 0);
      repeat (30) begin
         @(posedge clock);
         chan_a_ready <= 1'($random(seed));
      end
      @(posedge clock);
      chan_a_ready <= 1;
      repeat (12) @(posedge clock);
      #1 chk("drain", q.size() + qb.size(), 0);
      $display("binding and stream done");
      close_out;
   end
endmodule // ddc_preset_select_channel_binding_tb
